// ==== tfs_pkg.sv ====
// Purpose: Shared constants and types for the task-file status/command block
// Assumes: One clock, synchronous active-low reset
// Notes:   Link addresses follow the task-file register order
package tfs_pkg;

	// ------------------------------------------------------------
	// Link register addresses (with altSel low unless noted)
	// ------------------------------------------------------------
	localparam logic [2:0] TF_ERROR   = 3'h1;
	localparam logic [2:0] TF_SECNUM  = 3'h3;
	localparam logic [2:0] TF_CYLLO   = 3'h4;
	localparam logic [2:0] TF_CYLHI   = 3'h5;
	localparam logic [2:0] TF_UNITHD  = 3'h6;
	localparam logic [2:0] TF_STATCMD = 3'h7; // Status read, command write
	localparam logic [2:0] TF_ALTSTAT = 3'h6; // With altSel high

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int UH_ONE_HI = 7;
	localparam int UH_LBA    = 6;
	localparam int UH_ONE_LO = 5;
	localparam int UH_UNIT   = 4;
	localparam int ST_BUSY   = 7;
	localparam int ST_READY  = 6;
	localparam int ST_FAULT  = 5;
	localparam int ST_SEEK   = 4;
	localparam int ST_DRQ    = 3;
	localparam int ST_FIXED_DATA_FLAG   = 2;
	localparam int ST_INDEX  = 1;
	localparam int ST_ERR    = 0;
	localparam int ER_ABORT  = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] UH_RESET = 8'ha0;
	localparam logic [7:0] ST_RESET = 8'h50;

	// ------------------------------------------------------------
	// Host-side APB register map
	// ------------------------------------------------------------
	localparam logic [7:0] HR_ACCESS = 8'h00;
	localparam logic [7:0] HR_RESULT = 8'h04;
	localparam int AC_ADDR_LO = 8;
	localparam int AC_ALT     = 11;
	localparam int AC_READ    = 12;
	localparam int RS_BUSY    = 8;
	localparam int RS_IRQ     = 9;
	localparam int RS_READY   = 10;

	// Decoded command classes
	typedef enum logic [3:0] {
		CMD_INVALID, CMD_READ, CMD_READ_LONG, CMD_WR_MULTI_NE,
		CMD_WR_NE, CMD_STANDBY_IMM, CMD_CHECK_PWR, CMD_SLEEP,
		CMD_RECAL, CMD_SEEK, CMD_OTHER
	} tfs_cmd_t;

endpackage

// ==== tfs_link_if.sv ====
// Purpose: Register access link between host controller and card
// Assumes: Strobes are one-cycle pulses on the common clock
// Notes:   rdAck follows rdStb by one cycle with rdData
interface tfs_link_if;
	logic [2:0] addr;
	logic       altSel;
	logic       rdStb;
	logic       wrStb;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic       rdAck;
	logic       intReqN;

	modport device (input addr, altSel, rdStb, wrStb, wrData,
		output rdData, rdAck, intReqN);
	modport host (output addr, altSel, rdStb, wrStb, wrData,
		input rdData, rdAck, intReqN);
endinterface

// ==== tfs_host.sv ====
// Purpose: Host controller end, APB slave that issues task-file accesses
// Assumes: Device answers a read one cycle after the strobe
// Notes:   Command writes refused until a status read shows ready
module tfs_host (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	tfs_link_if.host         link
);
	import tfs_pkg::*;

	logic        busy_ff;
	logic [7:0]  result_ff;
	logic        devReady_ff;
	logic        lastRead_ff;
	logic [2:0]  addr_ff;
	logic        alt_ff;
	logic        rdStb_ff;
	logic        wrStb_ff;
	logic [7:0]  wrData_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        acc;
	logic        isCmd;

	assign acc   = psel & penable & ~pready_ff;
	assign isCmd = pwdata[AC_ADDR_LO +: 3] == TF_STATCMD
		& ~pwdata[AC_ALT] & ~pwdata[AC_READ];

	// ------------------------------------------------------------
	// APB slave: one wait state, then ready
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= acc;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
			if (acc) begin
				if (paddr == HR_RESULT && !pwrite) begin
					prdata_ff <= {21'h0, devReady_ff, ~link.intReqN,
						busy_ff, result_ff};
				end else if (paddr == HR_ACCESS && pwrite) begin
					// Busy link, or a command write while the device is unready, refuses the access
					pslverr_ff <= busy_ff | (isCmd & ~devReady_ff); // [R16]
				end else begin
					pslverr_ff <= 1'b1;
				end
			end
		end
	end

	// Launch a link access on an accepted write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_ff     <= 1'b0;
			rdStb_ff    <= 1'b0;
			wrStb_ff    <= 1'b0;
			addr_ff     <= 3'h0;
			alt_ff      <= 1'b0;
			wrData_ff   <= 8'h0;
			lastRead_ff <= 1'b0;
		end else begin
			rdStb_ff <= 1'b0;
			wrStb_ff <= 1'b0;
			if (acc && pwrite && paddr == HR_ACCESS && !busy_ff
				&& !(isCmd && !devReady_ff)) begin
				addr_ff     <= pwdata[AC_ADDR_LO +: 3];
				alt_ff      <= pwdata[AC_ALT];
				wrData_ff   <= pwdata[7:0];
				lastRead_ff <= pwdata[AC_READ];
				rdStb_ff    <= pwdata[AC_READ];
				wrStb_ff    <= ~pwdata[AC_READ];
				busy_ff     <= pwdata[AC_READ];
			end else if (link.rdAck) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// Capture read data; track readiness from status reads
	always_ff @(posedge clk) begin
		if (!nrst) begin
			result_ff   <= 8'h0;
			devReady_ff <= 1'b0;
		end else if (link.rdAck) begin
			result_ff <= link.rdData;
			if ((!alt_ff && addr_ff == TF_STATCMD)
				|| (alt_ff && addr_ff == TF_ALTSTAT))
				// Other bits are meaningless while busy is set
				devReady_ff <= ~link.rdData[ST_BUSY]
					& link.rdData[ST_READY]; // [R8]
		end else if (wrStb_ff && addr_ff == TF_STATCMD && !alt_ff) begin
			devReady_ff <= 1'b0;
		end
	end

	assign link.addr   = addr_ff;
	assign link.altSel = alt_ff;
	assign link.rdStb  = rdStb_ff;
	assign link.wrStb  = wrStb_ff;
	assign link.wrData = wrData_ff;
	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;

endmodule

// ==== tfs_device.sv ====
// Purpose: Card end: unit/head select, status flags and command decode
// Assumes: Media engine reports completion through the user-side ports
// Notes:   Reads answer one cycle after the strobe
// Summary of operation
// R1: Unit/head bits 7 and 5 read one
// R2: Bit 6 picks block or cylinder addressing
// R3: Block number built from four task-file fields
// R4: Unit bit must match socket unit number
// R5: Bits 3-0 hold head, bit 3 MSB
// R6: Status read drops interrupt request
// R7: Command write clears 0,4,6, sets busy
// R8: Busy high makes other status bits invalid
// R9: Media commands need ready and seek done
// R10: Write fault sets status bit 5
// R11: Data request flag, cleared by new command
// R12: Corrected data sets status bit 2
// R13: Status bit 1 always reads zero
// R14: Error bit set on failure, cleared next
// R15: Alternate status mirrors, leaves interrupt alone
// R16: Host writes command only when ready
// R17: CDH decodes multi-sector write without erase
// R18: 38H decodes sector write without erase
// R19: 20H/21H read, 22H/23H long read
// R20: Power commands decode from two codes each
// R21: Aborted command sets abort error bit
// R22: Recalibrate and seek match upper nibble
module tfs_device (
	input  wire logic                clk,
	input  wire logic                nrst,
	tfs_link_if.device               link,
	input  wire logic                socketUnit,
	input  wire logic                mediaReady,
	input  wire logic                opDone,
	input  wire logic                opErr,
	input  wire logic                opFault,
	input  wire logic                opCorr,
	input  wire logic                drqSet,
	input  wire logic                drqClr,
	output tfs_pkg::tfs_cmd_t        cmdKind,
	output logic                     cmdStb,
	output logic                     lbaMode,
	output logic              [27:0] blockAddr,
	output logic              [3:0]  headNum,
	output logic                     unitSel
);
	import tfs_pkg::*;

	// Map a command code to its class
	function automatic tfs_cmd_t decodeCmd(input logic [7:0] c);
		tfs_cmd_t k;
		k = CMD_INVALID;
		unique case (c)
			8'hcd: k = CMD_WR_MULTI_NE; // [R17]
			8'h38: k = CMD_WR_NE; // [R18]
			8'h20, 8'h21: k = CMD_READ; // [R19]
			8'h22, 8'h23: k = CMD_READ_LONG; // [R19]
			8'he0, 8'h94: k = CMD_STANDBY_IMM; // [R20]
			8'he5, 8'h98: k = CMD_CHECK_PWR; // [R20]
			8'he6, 8'h99: k = CMD_SLEEP; // [R20]
			8'h90, 8'hc0, 8'h50, 8'hec, 8'he3, 8'h97, 8'he1, 8'h95,
			8'h91, 8'he4, 8'hc4, 8'h40, 8'h41, 8'h03, 8'hef, 8'hc6,
			8'he2, 8'h96, 8'h87, 8'hf5, 8'he8, 8'h32, 8'h33, 8'hc5,
			8'h30, 8'h31, 8'h3c: k = CMD_OTHER;
			default: begin
				if (c[7:4] == 4'h1)
					k = CMD_RECAL; // [R22]
				else if (c[7:4] == 4'h7)
					k = CMD_SEEK; // [R22]
			end
		endcase
		return k;
	endfunction

	// True for classes that move or position media data
	function automatic logic isMedia(input tfs_cmd_t k);
		return k == CMD_READ || k == CMD_READ_LONG || k == CMD_SEEK
			|| k == CMD_WR_MULTI_NE || k == CMD_WR_NE;
	endfunction

	logic [7:0] unitHd_ff;
	logic [7:0] secNum_ff;
	logic [7:0] cylLo_ff;
	logic [7:0] cylHi_ff;
	logic [7:0] status_ff;
	logic       abort_ff;
	logic       irq_ff;
	logic       pendAbort_ff;
	tfs_cmd_t   cmdKind_ff;
	logic       cmdStb_ff;
	logic [7:0] rdData_ff;
	logic       rdAck_ff;
	logic       mine;
	logic       cmdWr;
	logic       statRd;
	logic       done;
	tfs_cmd_t   newKind;
	logic       refuse;

	// Only the addressed unit responds
	assign mine    = unitHd_ff[UH_UNIT] == socketUnit; // [R4]
	assign cmdWr   = link.wrStb & ~link.altSel & mine
		& link.addr == TF_STATCMD;
	assign statRd  = link.rdStb & ~link.altSel & mine
		& link.addr == TF_STATCMD;
	assign newKind = decodeCmd(link.wrData);
	// Media request refused unless ready and seek done before the write
	assign refuse  = newKind == CMD_INVALID | status_ff[ST_FAULT]
		| (isMedia(newKind)
		& ~(status_ff[ST_READY] & status_ff[ST_SEEK])); // [R9]
	assign done    = status_ff[ST_BUSY] & (opDone | pendAbort_ff);

	// ------------------------------------------------------------
	// Task-file parameter registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			unitHd_ff <= UH_RESET;
			secNum_ff <= 8'h0;
			cylLo_ff  <= 8'h0;
			cylHi_ff  <= 8'h0;
		end else if (link.wrStb && !link.altSel) begin
			unique case (link.addr)
				TF_UNITHD: begin
					// Unit bit is written by both units
					unitHd_ff <= link.wrData | UH_RESET; // [R1] [R4]
				end
				TF_SECNUM: if (mine) secNum_ff <= link.wrData;
				TF_CYLLO: if (mine) cylLo_ff <= link.wrData;
				TF_CYLHI: if (mine) cylHi_ff <= link.wrData;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_ff    <= ST_RESET;
			pendAbort_ff <= 1'b0;
		end else begin
			pendAbort_ff <= 1'b0;
			if (cmdWr && !status_ff[ST_BUSY]) begin
				status_ff[ST_ERR]   <= 1'b0; // [R7] [R14]
				status_ff[ST_SEEK]  <= 1'b0; // [R7]
				status_ff[ST_READY] <= 1'b0; // [R7]
				status_ff[ST_BUSY]  <= 1'b1; // [R7] [R8]
				status_ff[ST_DRQ]   <= drqSet; // [R11]
				pendAbort_ff        <= refuse;
			end else begin
				if (done) begin
					status_ff[ST_BUSY]  <= 1'b0;
					status_ff[ST_READY] <= mediaReady;
					status_ff[ST_SEEK]  <= 1'b1;
					status_ff[ST_ERR]   <= pendAbort_ff | opErr; // [R14]
					status_ff[ST_FAULT] <= opFault & ~pendAbort_ff; // [R10]
					status_ff[ST_FIXED_DATA_FLAG]  <= opCorr & ~pendAbort_ff; // [R12]
				end else if (!status_ff[ST_BUSY]) begin
					status_ff[ST_READY] <= mediaReady;
				end
				// Set wins over clear
				if (drqSet)
					status_ff[ST_DRQ] <= 1'b1; // [R11]
				else if (drqClr)
					status_ff[ST_DRQ] <= 1'b0;
			end
			status_ff[ST_INDEX] <= 1'b0; // [R13]
		end
	end

	// Abort bit in the error register
	always_ff @(posedge clk) begin
		if (!nrst)
			abort_ff <= 1'b0;
		else if (done)
			abort_ff <= pendAbort_ff; // [R21]
		else if (cmdWr && !status_ff[ST_BUSY])
			abort_ff <= 1'b0;
	end

	// Interrupt request: raised at completion, dropped by status read
	always_ff @(posedge clk) begin
		if (!nrst)
			irq_ff <= 1'b0;
		else if (done)
			irq_ff <= 1'b1;
		else if (statRd)
			irq_ff <= 1'b0; // [R6] [R15]
	end

	// Command issue towards the media engine
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cmdKind_ff <= CMD_INVALID;
			cmdStb_ff  <= 1'b0;
		end else begin
			cmdStb_ff <= cmdWr & ~status_ff[ST_BUSY] & ~refuse;
			if (cmdWr && !status_ff[ST_BUSY])
				cmdKind_ff <= newKind;
		end
	end

	// ------------------------------------------------------------
	// Read path; alternate status shares the status flops
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdData_ff <= 8'h0;
			rdAck_ff  <= 1'b0;
		end else begin
			rdAck_ff  <= link.rdStb;
			rdData_ff <= 8'h0;
			if (link.rdStb && mine) begin
				if (link.altSel) begin
					if (link.addr == TF_ALTSTAT)
						rdData_ff <= status_ff; // [R15]
				end else begin
					unique case (link.addr)
						TF_STATCMD: rdData_ff <= status_ff; // [R8]
						TF_UNITHD: rdData_ff <= unitHd_ff; // [R1]
						TF_SECNUM: rdData_ff <= secNum_ff;
						TF_CYLLO: rdData_ff <= cylLo_ff;
						TF_CYLHI: rdData_ff <= cylHi_ff;
						TF_ERROR: rdData_ff[ER_ABORT] <= abort_ff;
						default: ;
					endcase
				end
			end
		end
	end

	assign link.rdData  = rdData_ff;
	assign link.rdAck   = rdAck_ff;
	assign link.intReqN = ~irq_ff;
	assign cmdKind      = cmdKind_ff;
	assign cmdStb       = cmdStb_ff;
	assign lbaMode      = unitHd_ff[UH_LBA]; // [R2]
	assign blockAddr    = {unitHd_ff[3:0], cylHi_ff,
		cylLo_ff, secNum_ff}; // [R3]
	assign headNum      = unitHd_ff[3:0]; // [R5]
	assign unitSel      = unitHd_ff[UH_UNIT];

endmodule

// ==== tfs_asserts.sv ====
// Purpose: Link checks between the host end and the card end
// Assumes: One clock, nrst synchronous and active low
// Notes:   Sees the interface signals only
module tfs_asserts
	import tfs_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [2:0] addr,
	input wire logic       altSel,
	input wire logic       rdStb,
	input wire logic       wrStb,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdData,
	input wire logic       rdAck,
	input wire logic       intReqN
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// Read answers
	// ------------------------------------------------------------
	a_ack_follows_read: assert property (rdStb |=> rdAck)
		else $error("read strobe got no acknowledge");
	a_ack_has_cause: assert property (rdAck |-> $past(rdStb))
		else $error("acknowledge without a read strobe");
	a_index_reads_zero: assert property (rdStb && !altSel && addr == TF_STATCMD |=> !rdData[ST_INDEX])
		else $error("index flag read as one");
	a_unit_fixed_ones: assert property (rdStb && !altSel && addr == TF_UNITHD |=> rdData[UH_ONE_HI] && rdData[UH_ONE_LO])
		else $error("unit/head fixed bits not one");

	// ------------------------------------------------------------
	// Interrupt request and strobes
	// ------------------------------------------------------------
	a_status_read_irq: assert property (rdStb && !altSel && addr == TF_STATCMD |=> intReqN)
		else $error("status read left request asserted");
	a_alt_read_irq: assert property (rdStb && altSel && addr == TF_ALTSTAT |=> !$rose(intReqN))
		else $error("alternate read dropped request");
	a_strobes_exclusive: assert property (!(rdStb && wrStb))
		else $error("read and write strobe together");
	a_write_one_pulse: assert property (wrStb |=> !wrStb)
		else $error("write strobe longer than one cycle");
endmodule

// ==== ata_task_file_status_command_tb.sv ====
// Purpose: Both ends joined, host driven over APB, card user side driven
// Assumes: Host answers one wait state, link reads polled through RESULT
// Notes:   Not-ready test runs last since mediaReady then stays low
module ata_task_file_status_command_tb import tfs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, v, w;
	logic [31:0] pwdata, prdata, r;
	logic        socketUnit, mediaReady, opDone, opErr, opFault, opCorr;
	logic        drqSet, drqClr, cmdStb, lbaMode, unitSel, e;
	tfs_cmd_t    cmdKind;
	logic [27:0] blockAddr;
	logic [3:0]  headNum;
	int          n_mismatch, checks_done, nStb;
	logic [7:0]  codes [17] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'hcd, 8'h38,
		8'he0, 8'h94, 8'he5, 8'h98, 8'he6, 8'h99, 8'h10, 8'h1f, 8'h70,
		8'h7a, 8'hec};
	tfs_cmd_t    kinds [17] = '{CMD_READ, CMD_READ, CMD_READ_LONG,
		CMD_READ_LONG, CMD_WR_MULTI_NE, CMD_WR_NE, CMD_STANDBY_IMM,
		CMD_STANDBY_IMM, CMD_CHECK_PWR, CMD_CHECK_PWR, CMD_SLEEP, CMD_SLEEP,
		CMD_RECAL, CMD_RECAL, CMD_SEEK, CMD_SEEK, CMD_OTHER};

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); end end

	// ------------------------------------------------------------
	// Clock, ends and checker
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	tfs_link_if link ();
	tfs_host tfs_host_i (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	tfs_device tfs_device_i (.clk(clk), .nrst(nrst), .link(link),
		.socketUnit(socketUnit), .mediaReady(mediaReady), .opDone(opDone),
		.opErr(opErr), .opFault(opFault), .opCorr(opCorr), .drqSet(drqSet),
		.drqClr(drqClr), .cmdKind(cmdKind), .cmdStb(cmdStb),
		.lbaMode(lbaMode), .blockAddr(blockAddr), .headNum(headNum),
		.unitSel(unitSel));
	tfs_asserts tfs_asserts_i (.clk(clk), .nrst(nrst), .addr(link.addr),
		.altSel(link.altSel), .rdStb(link.rdStb), .wrStb(link.wrStb),
		.wrData(link.wrData), .rdData(link.rdData), .rdAck(link.rdAck),
		.intReqN(link.intReqN));
	// Counts accepted commands
	always @(posedge clk) begin
		if (cmdStb === 1'b1) nStb++;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	// One APB transfer, result left in r and e
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits for the answer; only the watchdog ends a hang
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Link read through the host, byte left in v
	task automatic link_rd(input logic [2:0] a, input logic alt);
		apb(1'b1, HR_ACCESS, {19'h0, 1'b1, alt, a, 8'h00});
		do apb(1'b0, HR_RESULT, 32'h0);
		while (r[RS_BUSY] !== 1'b0);
		v = r[7:0];
	endtask
	task automatic link_wr(input logic [2:0] a, input logic [7:0] d);
		apb(1'b1, HR_ACCESS, {21'h0, a, d});
	endtask
	// Command write followed by a status read
	task automatic issue(input logic [7:0] c);
		link_wr(TF_STATCMD, c);
		link_rd(TF_STATCMD, 1'b0);
	endtask
	// Media engine completion pulse
	task automatic finish_op(input logic er, input logic fa, input logic co);
		@(posedge clk);
		opDone <= 1'b1;
		opErr <= er;
		opFault <= fa;
		opCorr <= co;
		@(posedge clk);
		opDone <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{socketUnit, opDone, opErr, opFault, opCorr, drqSet, drqClr} = '0;
		mediaReady = 1'b1;
		{n_mismatch, checks_done, nStb} = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		link_wr(TF_STATCMD, 8'h20);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(e, 1'b1)
		link_rd(TF_UNITHD, 1'b0);
		`CHK(v, 8'ha0)
		`CHK(lbaMode, 1'b0)
		link_rd(TF_STATCMD, 1'b0);
		`CHK(v, 8'h50)
		$display("test reset done");
		link_wr(TF_UNITHD, 8'h4b);
		link_wr(TF_SECNUM, 8'h11);
		link_wr(TF_CYLLO, 8'h22);
		link_wr(TF_CYLHI, 8'h33);
		link_rd(TF_UNITHD, 1'b0);
		`CHK(v, 8'heb)
		`CHK(lbaMode, 1'b1)
		`CHK(headNum, 4'hb)
		`CHK(unitSel, 1'b0)
		`CHK(blockAddr, 28'hb332211)
		socketUnit <= 1'b1;
		link_rd(TF_STATCMD, 1'b0);
		`CHK(v, 8'h00)
		socketUnit <= 1'b0;
		link_rd(TF_STATCMD, 1'b0);
		$display("test unit head done");
		for (int i = 0; i < 17; i++) begin
			issue(codes[i]);
			`CHK(v & 8'hd1, 8'h80)
			`CHK(cmdKind, kinds[i])
			finish_op(1'b0, 1'b0, 1'b0);
			`CHK(link.intReqN, 1'b0)
			link_rd(TF_ALTSTAT, 1'b1);
			w = v;
			`CHK(link.intReqN, 1'b0)
			`CHK(r[RS_IRQ], 1'b1)
			link_rd(TF_STATCMD, 1'b0);
			`CHK(w, v)
			`CHK(v & 8'hc1, 8'h40)
			`CHK(r[RS_READY], 1'b1)
			`CHK(link.intReqN, 1'b1)
		end
		`CHK(nStb, 17)
		$display("test decode done");
		issue(8'h00);
		`CHK(v & 8'h81, 8'h01)
		link_rd(TF_ERROR, 1'b0);
		`CHK(v, 8'h04)
		`CHK(nStb, 17)
		$display("test invalid done");
		issue(8'h20);
		`CHK(v & 8'hd1, 8'h80)
		@(posedge clk);
		drqSet <= 1'b1;
		@(posedge clk);
		drqSet <= 1'b0;
		finish_op(1'b1, 1'b1, 1'b1);
		link_rd(TF_STATCMD, 1'b0);
		`CHK(v & 8'hed, 8'h6d)
		issue(8'h20);
		`CHK(v & 8'h89, 8'h01)
		link_rd(TF_ERROR, 1'b0);
		`CHK(v, 8'h04)
		`CHK(nStb, 18)
		$display("test fault done");
		// Ready drops after the last status read; a seek is then refused
		mediaReady <= 1'b0;
		issue(8'h70);
		`CHK(v & 8'hc1, 8'h01)
		`CHK(nStb, 18)
		$display("test not ready done");
		complete_run;
	end
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run;
	end
endmodule
